// [rca_pkg.sv]
package rca_pkg;
    // register byte offsets on the plain register port
    localparam int RCA_AW = 4;
    localparam logic [RCA_AW-1:0] RCA_OFS_CTRL = 4'h0;
    localparam logic [RCA_AW-1:0] RCA_OFS_ALARM = 4'h4;
    localparam logic [RCA_AW-1:0] RCA_OFS_TIME = 4'h8;

    // control register bit positions
    localparam int RCA_CTL_ENABLE = 15;
    localparam int RCA_CTL_FREEZE = 14;
    localparam int RCA_CTL_IDLE_STOP = 13;
    localparam int RCA_CTL_OUT_SEL = 7;
    localparam int RCA_CTL_CLK_RUN = 6;
    localparam int RCA_CTL_UNLOCK = 3;
    localparam int RCA_CTL_RD_SYNC = 2;
    localparam int RCA_CTL_HALF = 1;
    localparam int RCA_CTL_OE = 0;

    // alarm control register bit positions
    localparam int RCA_ALM_EN = 15;
    localparam int RCA_ALM_CHIME = 14;
    localparam int RCA_ALM_PIV = 13;
    localparam int RCA_ALM_SYNC = 12;
    localparam int RCA_ALM_MASK_LO = 8;
    localparam int RCA_ALM_RPT_LO = 0;

    // seconds field inside the time value register
    localparam int RCA_SEC_LO = 8;
    localparam int RCA_SEC_HI = 14;

    // values after power-on reset
    localparam logic [31:0] RCA_RDATA_RST = 32'h0000_0000;
    localparam logic [7:0] RCA_RPT_RST = 8'h00;
    localparam logic [3:0] RCA_MASK_RST = 4'h0;
    localparam logic [3:0] RCA_SYNC_RST = 4'h0;
endpackage : rca_pkg

// [rca_alarm_if.sv]
`timescale 1ns/1ps
// carries alarm register traffic between the control block and the alarm field logic
interface rca_alarm_if;
    logic wr;
    logic [15:0] wdata;
    logic event_p;
    logic sync_lvl;
    logic [15:0] rdata;
    logic pulse;
    modport ctl (output wr, output wdata, output event_p, output sync_lvl,
                 input rdata, input pulse);
    modport alarm (input wr, input wdata, input event_p, input sync_lvl,
                   output rdata, output pulse);
endinterface : rca_alarm_if

// [rca_alarm_ctl.sv]
`timescale 1ns/1ps
module rca_alarm_ctl (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    rca_alarm_if.alarm bus
);
    import rca_pkg::*;

    typedef struct packed {
        logic en;
        logic chime;
        logic pulse_initial_value;
        logic [3:0] mask;
        logic [7:0] rpt;
        logic pulse;
    } rca_alm_s;

    rca_alm_s q;
    rca_alm_s d;

    // field updates; a software write lands after the hardware event so it wins
    always_comb begin
        d = q;
        if (!q.en) begin
            d.pulse = q.pulse_initial_value; // pulse idles at its initial value while disarmed
        end
        if (bus.event_p && q.en) begin
            d.pulse = ~q.pulse;
            if (q.rpt == 8'h00 && !q.chime) begin
                d.en = 1'b0;
            end else begin
                d.rpt = 8'(q.rpt - 8'h01); // chime lets the count wrap to 0xff
            end
        end
        if (bus.wr) begin
            d.en = bus.wdata[RCA_ALM_EN];
            d.chime = bus.wdata[RCA_ALM_CHIME];
            d.mask = bus.wdata[RCA_ALM_MASK_LO +: 4];
            d.rpt = bus.wdata[RCA_ALM_RPT_LO +: 8];
            if (!q.en) begin
                d.pulse_initial_value = bus.wdata[RCA_ALM_PIV]; // locked while the alarm is armed
            end
        end
    end

    // power-on reset only
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            q <= '{en: 1'b0, chime: 1'b0, pulse_initial_value: 1'b0, mask: RCA_MASK_RST,
                   rpt: RCA_RPT_RST, pulse: 1'b0};
        end else begin
            q <= d;
        end
    end

    // read view; sync flag is status only
    assign bus.rdata = {q.en, q.chime, q.pulse_initial_value, bus.sync_lvl, q.mask, q.rpt};
    assign bus.pulse = q.pulse;

    property p_auto_clear;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        bus.event_p && q.en && q.rpt == 8'h00 && !q.chime && !bus.wr |=> !q.en;
    endproperty
    a_auto_clear: assert property (p_auto_clear)
        else $error("alarm enable not cleared at last alarm");

    property p_rpt_dec;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        bus.event_p && q.en && q.rpt != 8'h00 && !bus.wr
            |=> q.en && q.rpt == 8'($past(q.rpt) - 8'h01);
    endproperty
    a_rpt_dec: assert property (p_rpt_dec)
        else $error("repeat count did not step down");

    property p_piv_lock;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        q.en && bus.wr |=> q.pulse_initial_value == $past(q.pulse_initial_value);
    endproperty
    a_piv_lock: assert property (p_piv_lock)
        else $error("pulse initial value changed while armed");

    c_last_alarm: cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
        bus.event_p && q.en && q.rpt == 8'h00 && !q.chime);
endmodule : rca_alarm_ctl

// [rca_regs.sv]
`timescale 1ns/1ps
// Operation
// - control and alarm registers return to reset values only on power-on reset.
// - a write to the module enable bit is taken only while the write unlock bit reads 1.
// - the debug freeze bit is writable only in debug mode and is held at 0 otherwise.
// - the output source select reaches the pin only while clock output enable is 1.
// - the write unlock bit can be set only while the write sequence is enabled.
// - the half-second flag is read-only and clears when the seconds field is written in a cycle without a half-second tick.
// - the pin enable is clock output enable ANDed with the module enable at bit 15.
// - the half-second flag reads 1 in the second half of each second, 0 in the first.
// - select 1 routes the seconds clock to the pin, select 0 the alarm pulse.
// - time and date writes are accepted only while write unlock is 1.
module rca_regs (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic [rca_pkg::RCA_AW-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic i_wr_seq_en,
    input wire logic i_debug_mode,
    input wire logic i_half_tick,
    input wire logic i_alarm_event,
    input wire logic i_sec_clk,
    input wire logic i_osc_running,
    input wire logic i_rollover_busy,
    input wire logic i_alarm_sync,
    output logic o_module_en,
    output logic o_debug_freeze,
    output logic o_idle_stop,
    output logic o_time_wr,
    output logic [31:0] o_time_wdata,
    output logic o_out_pin,
    output logic o_out_pin_oe_n
);
    import rca_pkg::*;

    // sync vector lanes: 0 seconds clock, 1 osc running, 2 rollover, 3 alarm sync
    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic en;
        logic debug_freeze;
        logic idle_stop;
        logic sel;
        logic unlock;
        logic half;
        logic oe;
        logic [31:0] rdata;
        logic time_wr;
        logic [31:0] time_data;
        logic pin;
        logic pin_oe_n;
    } rca_ctl_s;

    rca_ctl_s q;
    rca_ctl_s d;
    rca_alarm_if alm ();

    // address decode shared by the read and write paths
    function automatic logic hit(input logic [RCA_AW-1:0] a, input logic [RCA_AW-1:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    logic wr_ctrl;
    logic wr_alarm;
    logic wr_time;
    logic [31:0] ctrl_view;

    // strobes qualified by address
    assign wr_ctrl = i_wr && hit(i_addr, RCA_OFS_CTRL);
    assign wr_alarm = i_wr && hit(i_addr, RCA_OFS_ALARM);
    assign wr_time = i_wr && hit(i_addr, RCA_OFS_TIME);

    // control register as software sees it; unimplemented bits read 0
    always_comb begin
        ctrl_view = 32'h0000_0000;
        ctrl_view[RCA_CTL_ENABLE] = q.en;
        ctrl_view[RCA_CTL_FREEZE] = q.debug_freeze;
        ctrl_view[RCA_CTL_IDLE_STOP] = q.idle_stop;
        ctrl_view[RCA_CTL_OUT_SEL] = q.sel;
        ctrl_view[RCA_CTL_CLK_RUN] = q.s2[1];
        ctrl_view[RCA_CTL_UNLOCK] = q.unlock;
        ctrl_view[RCA_CTL_RD_SYNC] = q.s2[2];
        ctrl_view[RCA_CTL_HALF] = q.half;
        ctrl_view[RCA_CTL_OE] = q.oe;
    end

    // alarm field logic rides the interface
    assign alm.wr = wr_alarm;
    assign alm.wdata = i_wdata[15:0];
    assign alm.event_p = i_alarm_event;
    assign alm.sync_lvl = q.s2[3];

    rca_alarm_ctl u_alarm (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .bus(alm.alarm)
    );

    // next-state of all control state
    always_comb begin
        d = q;
        // pin-side levels cross through two flops before anything reads them
        d.s1 = {i_alarm_sync, i_rollover_busy, i_osc_running, i_sec_clk};
        d.s2 = q.s1;
        if (wr_ctrl) begin
            d.idle_stop = i_wdata[RCA_CTL_IDLE_STOP];
            d.sel = i_wdata[RCA_CTL_OUT_SEL];
            d.oe = i_wdata[RCA_CTL_OE];
            if (q.unlock) begin
                d.en = i_wdata[RCA_CTL_ENABLE];
            end
            if (i_wdata[RCA_CTL_UNLOCK]) begin
                d.unlock = q.unlock | i_wr_seq_en;
            end else begin
                d.unlock = 1'b0; // locking again needs no sequence
            end
            d.debug_freeze = i_wdata[RCA_CTL_FREEZE];
        end
        if (!i_debug_mode) begin
            d.debug_freeze = 1'b0;
        end
        // time writes pass on only while unlocked
        d.time_wr = wr_time && q.unlock;
        if (wr_time && q.unlock) begin
            d.time_data = i_wdata;
        end
        if (wr_time && q.unlock) begin
            d.half = 1'b0; // seconds rewrite restarts the second
        end
        if (i_half_tick) begin
            d.half = ~q.half; // tick wins over a same-cycle clear
        end
        // read data stands for exactly the cycle after the strobe
        d.rdata = 32'h0000_0000;
        if (i_rd) begin
            if (hit(i_addr, RCA_OFS_CTRL)) begin
                d.rdata = ctrl_view;
            end else if (hit(i_addr, RCA_OFS_ALARM)) begin
                d.rdata = {16'h0000, alm.rdata};
            end
        end
        // output pin: source mux only counts when enabled, disabled pin idles low
        d.pin_oe_n = ~(q.en & q.oe);
        d.pin = (q.en & q.oe) ? (q.sel ? q.s2[0] : alm.pulse) : 1'b0;
    end

    // only the power-on reset reaches this state; other resets are not wired
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            q <= '{s1: RCA_SYNC_RST, s2: RCA_SYNC_RST, en: 1'b0, debug_freeze: 1'b0,
                   idle_stop: 1'b0, sel: 1'b0, unlock: 1'b0, half: 1'b0,
                   oe: 1'b0, rdata: RCA_RDATA_RST, time_wr: 1'b0,
                   time_data: RCA_RDATA_RST, pin: 1'b0, pin_oe_n: 1'b1};
        end else begin
            q <= d;
        end
    end

    // outputs, all from flops
    assign o_rdata = q.rdata;
    assign o_module_en = q.en;
    assign o_debug_freeze = q.debug_freeze;
    assign o_idle_stop = q.idle_stop;
    assign o_time_wr = q.time_wr;
    assign o_time_wdata = q.time_data;
    assign o_out_pin = q.pin;
    assign o_out_pin_oe_n = q.pin_oe_n;

    property p_en_lock;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        wr_ctrl && !q.unlock |=> q.en == $past(q.en);
    endproperty
    a_en_lock: assert property (p_en_lock)
        else $error("enable changed while locked");

    property p_unlock_seq;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        !q.unlock && !i_wr_seq_en |=> !q.unlock;
    endproperty
    a_unlock_seq: assert property (p_unlock_seq)
        else $error("unlock set outside write sequence");

    property p_freeze;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        !i_debug_mode |=> !q.debug_freeze;
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("freeze bit set outside debug mode");

    property p_half_clr;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        wr_time && q.unlock && !i_half_tick |=> !q.half;
    endproperty
    a_half_clr: assert property (p_half_clr)
        else $error("half-second flag not cleared by seconds write");

    property p_pin_oe;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        ##1 o_out_pin_oe_n == !($past(q.en) && $past(q.oe));
    endproperty
    a_pin_oe: assert property (p_pin_oe)
        else $error("pin enable is not enable AND output enable");

    property p_route;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        q.en && q.oe && q.sel |=> o_out_pin == $past(q.s2[0]);
    endproperty
    a_route: assert property (p_route)
        else $error("seconds clock not routed to pin");

    property p_time_lock;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        wr_time && !q.unlock |=> !o_time_wr;
    endproperty
    a_time_lock: assert property (p_time_lock)
        else $error("time write passed while locked");

    property p_rd_ctrl;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        i_rd && hit(i_addr, RCA_OFS_CTRL) |=> o_rdata[RCA_CTL_UNLOCK] == $past(q.unlock)
            ##1 o_rdata == 32'h0000_0000 || $past(i_rd);
    endproperty
    a_rd_ctrl: assert property (p_rd_ctrl)
        else $error("control read data wrong or held too long");

    c_unlock: cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
        wr_ctrl && i_wdata[RCA_CTL_UNLOCK] && i_wr_seq_en);
    c_pin_on: cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
        !o_out_pin_oe_n && o_out_pin);
endmodule : rca_regs

// [test_rca_regs.sv]
`timescale 1ns/1ps
module test_rca_regs;
    import rca_pkg::*;
    logic i_ref_clk, i_nrst, i_wr, i_rd, i_wr_seq_en, i_debug_mode, i_half_tick;
    logic i_alarm_event, i_sec_clk, i_osc_running, i_rollover_busy, i_alarm_sync;
    logic [RCA_AW-1:0] i_addr;
    logic [31:0] i_wdata, o_rdata, o_time_wdata, rv;
    logic o_module_en, o_debug_freeze, o_idle_stop, o_time_wr, o_out_pin, o_out_pin_oe_n;
    int errors = 0;
    int num_checks = 0;

    rca_regs rca_regs_i (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_wr_seq_en(i_wr_seq_en), .i_debug_mode(i_debug_mode), .i_half_tick(i_half_tick),
        .i_alarm_event(i_alarm_event), .i_sec_clk(i_sec_clk), .i_osc_running(i_osc_running),
        .i_rollover_busy(i_rollover_busy), .i_alarm_sync(i_alarm_sync),
        .o_module_en(o_module_en), .o_debug_freeze(o_debug_freeze), .o_idle_stop(o_idle_stop),
        .o_time_wr(o_time_wr), .o_time_wdata(o_time_wdata), .o_out_pin(o_out_pin),
        .o_out_pin_oe_n(o_out_pin_oe_n));

    // 125 MHz reference clock
    initial begin
        i_ref_clk = 1'b0;
        forever #4 i_ref_clk = ~i_ref_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk

    // one-cycle write strobe, launched right after an edge
    task automatic wr(input logic [RCA_AW-1:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe, so sample just after that edge
    task automatic rd(input logic [RCA_AW-1:0] a, output logic [31:0] d);
        @(posedge i_ref_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask : rd

    task automatic settle(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask : settle

    task automatic pulse_tick(input bit alarm);
        @(posedge i_ref_clk);
        if (alarm) i_alarm_event <= 1'b1; else i_half_tick <= 1'b1;
        @(posedge i_ref_clk);
        i_alarm_event <= 1'b0;
        i_half_tick <= 1'b0;
        settle(1);
    endtask : pulse_tick

    task automatic test_reset;
        rd(RCA_OFS_CTRL, rv);
        chk(rv, 32'h0000_0000, "control after reset");
        rd(RCA_OFS_ALARM, rv);
        chk(rv, 32'h0000_0000, "alarm after reset");
        rd(4'hc, rv);
        chk(rv, 32'h0000_0000, "unmapped read");
        chk({31'h0, o_out_pin_oe_n}, 32'h0000_0001, "pin enable after reset");
        $display("test reset done");
    endtask : test_reset

    task automatic test_unlock;
        wr(RCA_OFS_TIME, 32'h0000_1200);
        #1 chk({31'h0, o_time_wr}, 32'h0000_0000, "locked time write");
        wr(RCA_OFS_CTRL, 32'h0000_8000);
        settle(1);
        chk({31'h0, o_module_en}, 32'h0000_0000, "enable while locked");
        wr(RCA_OFS_CTRL, 32'h0000_0008);
        rd(RCA_OFS_CTRL, rv);
        chk(rv, 32'h0000_0000, "unlock without sequence");
        @(posedge i_ref_clk);
        i_wr_seq_en <= 1'b1;
        wr(RCA_OFS_CTRL, 32'h0000_0008);
        i_wr_seq_en <= 1'b0;
        rd(RCA_OFS_CTRL, rv);
        chk(rv, 32'h0000_0008, "unlock with sequence");
        wr(RCA_OFS_CTRL, 32'h0000_8008);
        settle(1);
        chk({31'h0, o_module_en}, 32'h0000_0001, "enable while unlocked");
        $display("test unlock done");
    endtask : test_unlock

    task automatic test_half;
        pulse_tick(1'b0);
        rd(RCA_OFS_CTRL, rv);
        chk({31'h0, rv[RCA_CTL_HALF]}, 32'h0000_0001, "second half");
        pulse_tick(1'b0);
        rd(RCA_OFS_CTRL, rv);
        chk({31'h0, rv[RCA_CTL_HALF]}, 32'h0000_0000, "first half");
        pulse_tick(1'b0);
        wr(RCA_OFS_CTRL, 32'h0000_8008);
        rd(RCA_OFS_CTRL, rv);
        chk({31'h0, rv[RCA_CTL_HALF]}, 32'h0000_0001, "flag read-only");
        wr(RCA_OFS_TIME, 32'h0000_3b00);
        #1 chk({31'h0, o_time_wr}, 32'h0000_0001, "time write pulse");
        chk(o_time_wdata, 32'h0000_3b00, "time write data");
        rd(RCA_OFS_CTRL, rv);
        chk({31'h0, rv[RCA_CTL_HALF]}, 32'h0000_0000, "flag cleared by seconds");
        $display("test half done");
    endtask : test_half

    task automatic test_freeze;
        wr(RCA_OFS_CTRL, 32'h0000_c008);
        settle(1);
        chk({31'h0, o_debug_freeze}, 32'h0000_0000, "freeze outside debug");
        @(posedge i_ref_clk);
        i_debug_mode <= 1'b1;
        wr(RCA_OFS_CTRL, 32'h0000_e008);
        settle(1);
        chk({31'h0, o_debug_freeze}, 32'h0000_0001, "freeze in debug");
        chk({31'h0, o_idle_stop}, 32'h0000_0001, "stop in idle set");
        @(posedge i_ref_clk);
        i_debug_mode <= 1'b0;
        settle(2);
        chk({31'h0, o_debug_freeze}, 32'h0000_0000, "freeze forced off");
        $display("test freeze done");
    endtask : test_freeze

    task automatic test_pin;
        wr(RCA_OFS_CTRL, 32'h0000_8088);
        settle(3);
        chk({30'h0, o_out_pin_oe_n, o_out_pin}, 32'h0000_0002, "output disabled");
        chk({31'h0, o_idle_stop}, 32'h0000_0000, "stop in idle cleared");
        wr(RCA_OFS_CTRL, 32'h0000_8089);
        i_sec_clk <= 1'b1;
        settle(6);
        chk({30'h0, o_out_pin_oe_n, o_out_pin}, 32'h0000_0001, "seconds clock high");
        @(posedge i_ref_clk);
        i_sec_clk <= 1'b0;
        settle(6);
        chk({31'h0, o_out_pin}, 32'h0000_0000, "seconds clock low");
        wr(RCA_OFS_ALARM, 32'h0000_2000);
        wr(RCA_OFS_CTRL, 32'h0000_8009);
        settle(4);
        chk({31'h0, o_out_pin}, 32'h0000_0001, "alarm pulse level");
        wr(RCA_OFS_CTRL, 32'h0000_0009);
        settle(4); // bus left idle right after the enable is cleared
        chk({30'h0, o_out_pin_oe_n, o_out_pin}, 32'h0000_0002, "module off gates pin");
        $display("test pin done");
    endtask : test_pin

    task automatic test_alarm;
        wr(RCA_OFS_ALARM, 32'h0000_8001);
        pulse_tick(1'b1);
        rd(RCA_OFS_ALARM, rv);
        chk(rv, 32'h0000_8000, "repeat decrements");
        pulse_tick(1'b1);
        rd(RCA_OFS_ALARM, rv);
        chk(rv, 32'h0000_0000, "alarm self-disables");
        wr(RCA_OFS_ALARM, 32'h0000_c500);
        pulse_tick(1'b1);
        rd(RCA_OFS_ALARM, rv);
        chk(rv, 32'h0000_c5ff, "chime keeps alarm");
        // armed alarm: the initial value bit must not take the write
        wr(RCA_OFS_ALARM, 32'h0000_e500);
        rd(RCA_OFS_ALARM, rv);
        chk(rv, 32'h0000_c500, "initial value locked while armed");
        $display("test alarm done");
    endtask : test_alarm

    // status levels cross two flops, so give them a few cycles before reading
    task automatic test_status;
        @(posedge i_ref_clk);
        {i_osc_running, i_rollover_busy, i_alarm_sync} <= 3'h7;
        settle(3);
        rd(RCA_OFS_CTRL, rv);
        chk(rv & 32'h0000_0044, 32'h0000_0044, "oscillator and rollover status");
        rd(RCA_OFS_ALARM, rv);
        chk(rv & 32'h0000_1000, 32'h0000_1000, "alarm sync status");
        @(posedge i_ref_clk);
        {i_osc_running, i_rollover_busy, i_alarm_sync} <= 3'h0;
        settle(3);
        rd(RCA_OFS_CTRL, rv);
        chk(rv & 32'h0000_0044, 32'h0000_0000, "status levels low");
        rd(RCA_OFS_ALARM, rv);
        chk(rv & 32'h0000_1000, 32'h0000_0000, "alarm sync low");
        $display("test status done");
    endtask : test_status

    task automatic summarize;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : summarize

    // main sequence: power-on reset, then the scenarios in order
    initial begin
        {i_nrst, i_wr, i_rd, i_wr_seq_en, i_debug_mode, i_half_tick} = 6'h00;
        {i_alarm_event, i_sec_clk, i_osc_running, i_rollover_busy, i_alarm_sync} = 5'h00;
        i_addr = '0;
        i_wdata = 32'h0000_0000;
        repeat (16) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        test_reset();
        test_unlock();
        test_half();
        test_freeze();
        test_pin();
        test_alarm();
        test_status();
        summarize();
    end

    // watchdog well beyond the roughly 150 cycles the scenarios need
    initial begin
        repeat (20000) @(posedge i_ref_clk);
        errors++;
        summarize();
    end
endmodule : test_rca_regs
